// ### pkg/p3io_pkg.sv
// Package: register map, reset values and field positions of the port three block
package p3io_pkg;
  // Register byte offsets (low 16 bits of haddr)
  localparam logic [15:0] P3IO_FUNC_SEL_OFS  = 16'hFFCA;
  localparam logic [15:0] P3IO_OUT_LATCH_OFS = 16'hFFD6;
  localparam logic [15:0] P3IO_PULLUP_OFS    = 16'hFFE1;
  localparam logic [15:0] P3IO_DIR_OFS       = 16'hFFE6;
  // Values after reset
  localparam logic [7:0]  P3IO_OUT_LATCH_RST = 8'h01;
  localparam logic [7:0]  P3IO_DIR_RST       = 8'h01;
  localparam logic [7:0]  P3IO_PULLUP_RST    = 8'h01;
  localparam logic [7:0]  P3IO_FUNC_SEL_RST  = 8'h39;
  // Function select field positions
  localparam int          P3IO_FS_EVL_BIT    = 7;
  localparam int          P3IO_FS_EVH_BIT    = 6;
  localparam int          P3IO_FS_TMH_BIT    = 2;
  localparam int          P3IO_FS_TML_BIT    = 1;
  // Writable bits of the function select register, others fixed at one
  localparam logic [7:0]  P3IO_FS_WMASK      = 8'hC6;
  // Writable pin bits of the latch, direction and pull-up registers
  localparam logic [7:0]  P3IO_PIN_MASK      = 8'hFE;
  localparam logic [7:0]  P3IO_ALL_ONES      = 8'hFF;
  // AHB transfer type and size codes
  localparam logic [1:0]  P3IO_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]  P3IO_HTRANS_SEQ    = 2'h3;
  localparam logic [2:0]  P3IO_HSIZE_WORD    = 3'h2;
endpackage

// ### test/p3io_pins_model.sv
// Partner model: external pin drivers and timer compare lines
`timescale 1ns/100ps
module p3io_pins_model (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] ext_level,
  input  wire logic [1:0] timer_level,
  output logic      [7:0] pin_in,
  output logic            tm_high,
  output logic            tm_low
);
  // Driven pins show the device level, released pins the outside drive
  assign pin_in  = (pin_oe & pin_out) | (~pin_oe & ext_level);
  assign tm_high = timer_level[1];
  assign tm_low  = timer_level[0];
endmodule

// ### test/p3io_port_bench.sv
// Bench: register and pin tests of the port three block
`timescale 1ns/100ps
module p3io_port_bench;
  import p3io_pkg::*;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, evl, evh, tm_h, tm_l;
  logic        clk_en = 1;
  logic [1:0]  htrans = 0, tmr = 2'h2;
  logic [7:0]  ext = 8'hA4, pin_in, pin_out, pin_oe, pull_en;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rdat;
  int          failures = 0, n_tests = 0, cycles = 0;
  initial begin
    forever #2 hclk = ~hclk;
  end
  p3io_port dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(P3IO_HSIZE_WORD), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .port_three_pin_in(pin_in), .port_three_pin_out(pin_out), .port_three_pin_oe(pin_oe),
    .port_three_pullup_en(pull_en), .timer_compare_high_output(tm_h),
    .timer_compare_low_output(tm_l), .async_event_low_input(evl), .async_event_high_input(evh));
  p3io_pins_model pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext),
    .timer_level(tmr), .pin_in(pin_in), .tm_high(tm_h), .tm_low(tm_l));
  task automatic stop_test();
    if (failures == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One single AHB-Lite transfer, address phase then data phase
  task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d);
    hsel   <= 1'b1;
    htrans <= P3IO_HTRANS_NONSEQ;
    hwrite <= w;
    haddr  <= {16'h0000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdat = hrdata;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk(rdat, {24'h000000, e});
  endtask
  // Hang guard
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      stop_test();
    end
  end
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(P3IO_FUNC_SEL_OFS, 8'h39);
    rd(P3IO_OUT_LATCH_OFS, 8'hA5);
    rd(P3IO_PULLUP_OFS, 8'h01);
    rd(P3IO_DIR_OFS, 8'hFF);
    chk({pin_oe, pull_en}, 16'h0000);
    chk({hreadyout, hresp}, 2'h2);
    wr(P3IO_DIR_OFS, 8'hFE);
    wr(P3IO_OUT_LATCH_OFS, 8'h5A);
    rd(P3IO_OUT_LATCH_OFS, 8'h5B);
    chk({pin_oe, pin_out}, 16'hFE5A);
    wr(P3IO_DIR_OFS, 8'h0F);
    wr(P3IO_OUT_LATCH_OFS, 8'h00);
    wr(P3IO_PULLUP_OFS, 8'hFF);
    rd(P3IO_OUT_LATCH_OFS, 8'hA1);
    rd(P3IO_PULLUP_OFS, 8'hFF);
    chk(pull_en, 8'hF0);
    wr(P3IO_DIR_OFS, 8'hFE);
    wr(P3IO_FUNC_SEL_OFS, 8'hFF);
    rd(P3IO_FUNC_SEL_OFS, 8'hFF);
    repeat (4) @(posedge hclk);
    chk({evl, evh, pin_oe[7:6], pin_out[2:1], pin_oe[2:1]}, 8'h8B);
    ext <= 8'h40;
    tmr <= 2'h1;
    repeat (4) @(posedge hclk);
    chk({evl, evh, pin_oe[7:6], pin_out[2:1], pin_oe[2:1]}, 8'h47);
    clk_en <= 1'b0;
    ext <= 8'h80;
    tmr <= 2'h2;
    repeat (4) @(posedge hclk);
    chk({evl, evh, pin_oe[7:6], pin_out[2:1], pin_oe[2:1]}, 8'h47);
    clk_en <= 1'b1;
    repeat (4) @(posedge hclk);
    chk({evl, evh, pin_oe[7:6], pin_out[2:1], pin_oe[2:1]}, 8'h8B);
    wr(P3IO_FUNC_SEL_OFS, 8'h00);
    rd(P3IO_FUNC_SEL_OFS, 8'h39);
    chk({pin_oe, pull_en}, 16'hFE00);
    rd(16'hFF00, 8'h00);
    stop_test();
  end
endmodule

// ### test/p3io_port_chk.sv
// Checker: port-level assertions of the port three block
`timescale 1ns/100ps
module p3io_port_chk
  import p3io_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        clk_en,
  input wire logic        hready,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hrdata,
  input wire logic [7:0]  port_three_pin_out,
  input wire logic [7:0]  port_three_pin_oe,
  input wire logic [7:0]  port_three_pullup_en,
  input wire logic        async_event_low_input,
  input wire logic        async_event_high_input
);
  // Read request seen at an address edge
  wire rd_req = hsel && hready && clk_en && htrans == P3IO_HTRANS_NONSEQ && !hwrite;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_pin0_off: assert property (!port_three_pin_out[0] && !port_three_pin_oe[0])
    else $error("pin zero driven");
  chk_pullup_input: assert property ((port_three_pullup_en & port_three_pin_oe) == 8'h00)
    else $error("pull-up on a driven pin");
  chk_evl_input: assert property (async_event_low_input |-> !port_three_pin_oe[7])
    else $error("event pin seven driven");
  chk_evh_input: assert property (async_event_high_input |-> !port_three_pin_oe[6])
    else $error("event pin six driven");
  chk_reset_pins: assert property ($rose(hresetn) |-> port_three_pin_oe == 8'h00)
    else $error("pins driven after reset");
  chk_dir_ones: assert property (rd_req && haddr[15:0] == P3IO_DIR_OFS |=> hrdata == 32'h000000FF)
    else $error("direction read not all ones");
  chk_fs_fixed: assert property (rd_req && haddr[15:0] == P3IO_FUNC_SEL_OFS |=> &hrdata[5:3])
    else $error("fixed select bits not one");
  chk_latch_bit0: assert property (rd_req && haddr[15:0] == P3IO_OUT_LATCH_OFS |=> hrdata[0])
    else $error("latch bit zero not one");
endmodule
bind p3io_port p3io_port_chk u_chk (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
  .hready(hready), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hrdata(hrdata), .port_three_pin_out(port_three_pin_out),
  .port_three_pin_oe(port_three_pin_oe), .port_three_pullup_en(port_three_pullup_en),
  .async_event_low_input(async_event_low_input), .async_event_high_input(async_event_high_input));

// ### verilog/p3io_port.sv
// Port three general-purpose I/O block with function select, AHB-Lite slave
`timescale 1ns/100ps
module p3io_port
  import p3io_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [7:0]  port_three_pin_in,
  output logic      [7:0]  port_three_pin_out,
  output logic      [7:0]  port_three_pin_oe,
  output logic      [7:0]  port_three_pullup_en,
  input  wire logic        timer_compare_high_output,
  input  wire logic        timer_compare_low_output,
  output logic             async_event_low_input,
  output logic             async_event_high_input
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0]  out_latch_r;
  logic [7:0]  direction_r;
  logic [7:0]  pullup_r;
  logic [7:0]  func_sel_r;
  logic [7:0]  pin_meta_r;
  logic [7:0]  pin_sync_r;
  logic        wr_pend_r;
  logic [15:0] wr_addr_r;
  logic [31:0] hrdata_nxt;

  // Per-pin results, one bit per port slice
  wire  [7:0]  pin_oe_nxt;
  wire  [7:0]  pin_out_nxt;
  wire  [7:0]  pin_pull_nxt;
  wire  [7:0]  port_rd;

  ////////////////////////////////////////////////////////////////////////////
  // Address phase decode
  // Only the low half of the address is decoded, so the map
  // repeats across the upper address bits
  wire         addr_valid = hsel && hready && (htrans == P3IO_HTRANS_NONSEQ ||
                                               htrans == P3IO_HTRANS_SEQ);
  wire         rd_req     = addr_valid && !hwrite;
  wire         wr_req     = addr_valid && hwrite;
  wire  [15:0] rd_ofs     = haddr[15:0];
  wire  [7:0]  wbyte      = hwdata[7:0];                                   // Upper bytes ignored

  // Read address hits
  wire         rd_hit_latch = rd_req && (rd_ofs == P3IO_OUT_LATCH_OFS);
  wire         rd_hit_dir   = rd_req && (rd_ofs == P3IO_DIR_OFS);
  wire         rd_hit_pull  = rd_req && (rd_ofs == P3IO_PULLUP_OFS);
  wire         rd_hit_func  = rd_req && (rd_ofs == P3IO_FUNC_SEL_OFS);

  // Write data phase strobes, one cycle after the address edge
  wire         wr_latch   = wr_pend_r && (wr_addr_r == P3IO_OUT_LATCH_OFS);
  wire         wr_dir     = wr_pend_r && (wr_addr_r == P3IO_DIR_OFS);
  wire         wr_pull    = wr_pend_r && (wr_addr_r == P3IO_PULLUP_OFS);
  wire         wr_func    = wr_pend_r && (wr_addr_r == P3IO_FUNC_SEL_OFS);

  ////////////////////////////////////////////////////////////////////////////
  // Write values with the reserved bits held at one
  wire  [7:0]  latch_wr_val = (wbyte & P3IO_PIN_MASK) | P3IO_OUT_LATCH_RST;
  wire  [7:0]  dir_wr_val   = (wbyte & P3IO_PIN_MASK) | P3IO_DIR_RST;
  wire  [7:0]  pull_wr_val  = (wbyte & P3IO_PIN_MASK) | P3IO_PULLUP_RST;
  wire  [7:0]  func_wr_val  = (wbyte & P3IO_FS_WMASK) | ~P3IO_FS_WMASK;

  // Next register values; a read right behind a write
  // sees the written byte, not the stale register
  wire  [7:0]  out_latch_nxt = wr_latch ? latch_wr_val : out_latch_r;
  wire  [7:0]  direction_nxt = wr_dir ? dir_wr_val : direction_r;
  wire  [7:0]  pullup_nxt    = wr_pull ? pull_wr_val : pullup_r;
  wire  [7:0]  func_sel_nxt  = wr_func ? func_wr_val : func_sel_r;

  ////////////////////////////////////////////////////////////////////////////
  // Pin function decode
  // Selected timer pins always drive, whatever the direction bit says;
  // selected event pins are always released
  wire  [7:0]  alt_sel    = func_sel_r & P3IO_FS_WMASK;
  wire  [7:0]  gpio_sel   = ~alt_sel & P3IO_PIN_MASK;
  wire  [7:0]  timer_drv  = {5'h00, func_sel_r[P3IO_FS_TMH_BIT],
                             func_sel_r[P3IO_FS_TML_BIT], 1'b0};
  wire  [7:0]  timer_lvl  = {5'h00, timer_compare_high_output,
                             timer_compare_low_output, 1'b0};

  // Event inputs follow the synchronised pin only while selected
  wire         evl_nxt    = func_sel_r[P3IO_FS_EVL_BIT] & pin_sync_r[7];
  wire         evh_nxt    = func_sel_r[P3IO_FS_EVH_BIT] & pin_sync_r[6];

  ////////////////////////////////////////////////////////////////////////////
  // Pin slices; bit 0 has no pin and reads as one
  // Drive and pull-up come from the registers, the level from the latch or the timer lines, the read
  // value from the forwarded registers and the synchronised pin
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      if (gi == 0) begin : g_none
        assign pin_oe_nxt[gi]   = 1'b0;
        assign pin_out_nxt[gi]  = 1'b0;
        assign pin_pull_nxt[gi] = 1'b0;
        assign port_rd[gi]      = 1'b1;
      end else begin : g_io
        wire is_gpio = gpio_sel[gi];
        wire is_drv  = direction_r[gi];
        wire alt_drv = timer_drv[gi];
        wire alt_lvl = timer_lvl[gi];
        assign pin_oe_nxt[gi]   = (is_gpio & is_drv) | alt_drv;
        assign pin_out_nxt[gi]  = alt_drv ? alt_lvl : out_latch_r[gi];
        assign pin_pull_nxt[gi] = is_gpio & ~is_drv & pullup_r[gi];
        assign port_rd[gi]      = direction_nxt[gi] ? out_latch_nxt[gi]
                                                    : pin_sync_r[gi];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read data mux, unmapped offsets read zero
  // Zero outside reads too, so the data bus idles quiet
  always_comb begin
    hrdata_nxt = 32'h0000_0000;
    if (rd_hit_latch) begin
      hrdata_nxt = {24'h000000, port_rd};
    end else if (rd_hit_dir) begin
      hrdata_nxt = {24'h000000, P3IO_ALL_ONES};
    end else if (rd_hit_pull) begin
      hrdata_nxt = {24'h000000, pullup_nxt};
    end else if (rd_hit_func) begin
      hrdata_nxt = {24'h000000, func_sel_nxt};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser, first stage; only the second stage reads it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta_r <= 8'h00;
    end else if (clk_en) begin
      pin_meta_r <= port_three_pin_in;
    end
  end

  // Pin synchroniser, second stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_sync_r <= 8'h00;
    end else if (clk_en) begin
      pin_sync_r <= pin_meta_r;
    end
  end

  // Write pending flag and its address
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 16'h0000;
    end else if (clk_en) begin
      if (hready) begin
        wr_pend_r <= wr_req;
        wr_addr_r <= haddr[15:0];
      end
    end
  end

  // Read data, held until the next ready edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (clk_en) begin
      if (hready) begin
        hrdata <= hrdata_nxt;
      end
    end
  end

  // Zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
    end else if (clk_en) begin
      hreadyout <= 1'b1;
    end
  end

  // Response always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else if (clk_en) begin
      hresp <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file; bit 0 and reserved bits stay at one
  // Output latch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_latch_r <= P3IO_OUT_LATCH_RST;
    end else if (clk_en) begin
      out_latch_r <= out_latch_nxt;
    end
  end

  // Direction
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      direction_r <= P3IO_DIR_RST;
    end else if (clk_en) begin
      direction_r <= direction_nxt;
    end
  end

  // Pull-up control
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pullup_r <= P3IO_PULLUP_RST;
    end else if (clk_en) begin
      pullup_r <= pullup_nxt;
    end
  end

  // Function select
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      func_sel_r <= P3IO_FUNC_SEL_RST;
    end else if (clk_en) begin
      func_sel_r <= func_sel_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops, so decode glitches never reach a pin
  // Registered pin levels
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_three_pin_out <= 8'h00;
    end else if (clk_en) begin
      port_three_pin_out <= pin_out_nxt;
    end
  end

  // Registered output enables
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_three_pin_oe <= 8'h00;
    end else if (clk_en) begin
      port_three_pin_oe <= pin_oe_nxt;
    end
  end

  // Registered pull-up enables
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_three_pullup_en <= 8'h00;
    end else if (clk_en) begin
      port_three_pullup_en <= pin_pull_nxt;
    end
  end

  // Low counter event input
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      async_event_low_input <= 1'b0;
    end else if (clk_en) begin
      async_event_low_input <= evl_nxt;
    end
  end

  // High counter event input
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      async_event_high_input <= 1'b0;
    end else if (clk_en) begin
      async_event_high_input <= evh_nxt;
    end
  end

endmodule
